// File: common/ssc_pkg.sv
// Package: register map, field layout and timing constants of the serial channel
`default_nettype none
package ssc_pkg;
  // ==========================================================
  // Register indices (byte address = 4 * index)
  localparam logic [15:0] SMCC_IDX = 16'hFFA0; // Mode and clock control
  localparam logic [15:0] SSS_IDX  = 16'hFFA1; // Status and start
  localparam logic [15:0] SDU_IDX  = 16'hFFA2; // Shift data upper
  localparam logic [15:0] SDL_IDX  = 16'hFFA3; // Shift data lower
  localparam logic [15:0] RXF_IDX  = 16'hFFA4; // Received word queue
  localparam int unsigned ADDR_W   = 18;       // APB address width
  // ==========================================================
  // Reset values
  localparam logic [7:0]  SMCC_RST = 8'h00;
  localparam logic [7:0]  SSS_RST  = 8'h80;
  localparam logic [7:0]  SDR_RST  = 8'h00;
  // ==========================================================
  // Field positions
  localparam int unsigned CSS_BIT  = 3;        // Clock source select
  localparam int unsigned LVL_BIT  = 6;        // Data out idle level
  localparam int unsigned OVR_BIT  = 5;        // Overrun flag
  localparam int unsigned RSV1_BIT = 1;        // Reserved, stored
  localparam int unsigned GO_BIT   = 0;        // Start flag
  localparam int unsigned RXV_BIT  = 16;       // Queue not empty
  localparam int unsigned RXF_BIT  = 17;       // Queue full
  // ==========================================================
  // Operation modes
  typedef enum logic [1:0] {
    SSC_M8   = 2'b00,
    SSC_M16  = 2'b01,
    SSC_MCON = 2'b10,
    SSC_MRSV = 2'b11
  } ssc_mode_t;
  // Transfer states
  typedef enum logic {SSC_IDLE, SSC_SHIFT} ssc_state_t;
  // ==========================================================
  // Half serial period in pclk cycles, per prescale code
  localparam logic [9:0]  HALF_TBL [8] = '{10'h200, 10'h080, 10'h020, 10'h010,
                                           10'h008, 10'h004, 10'h002, 10'h001};
  localparam logic [3:0]  LEN8_M1  = 4'h7;     // Last bit index, 8-bit
  localparam logic [3:0]  LEN16_M1 = 4'hF;     // Last bit index, 16-bit
  localparam int unsigned FIFO_W   = 16;
  localparam int unsigned FIFO_D   = 8;
endpackage
`default_nettype wire

// File: core/ssc_sync.sv
// Two-flop synchroniser for pin inputs
`default_nettype none
module ssc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  // ==========================================================
  // Stage one is read by stage two only
  logic [W-1:0] meta_ff; // First stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      d_out   <= '0;
    end else begin
      meta_ff <= d_in;
      d_out   <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// File: core/ssc_fifo.sv
// Received-word queue with valid/ready on both sides
`default_nettype none
module ssc_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  // ==========================================================
  // Storage and pointers
  logic [W-1:0]  mem [D];      // Word store
  logic [AW-1:0] wp_ff;        // Write pointer
  logic [AW-1:0] rp_ff;        // Read pointer
  logic [AW:0]   cnt_ff;       // Words held
  logic          push;
  logic          pop;
  // Room while fewer than D words are held; an empty queue always accepts
  assign in_ready  = (cnt_ff < (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rp_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // Pointers wrap at the power-of-two depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= push ? wp_ff + 1'b1 : wp_ff;
      rp_ff  <= pop ? rp_ff + 1'b1 : rp_ff;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Data array has no reset; out_data shows mem[rp_ff] even while the queue is empty
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: core/ssc_core.sv
// Clocked synchronous serial channel, 8/16-bit, with APB register slave
//
// Added by the designer: the APB slave port.
`default_nettype none
module ssc_core
  import ssc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sck_i,
  output logic                   sck_o,
  output logic                   sck_oe,
  input  wire logic              si_i,
  output logic                   so_o,
  output logic                   irq_done
);
  // ==========================================================
  // State registers
  logic [7:0]  scr_ff, nxt_scr;         // Mode and clock control
  ssc_state_t  state_ff, nxt_state;     // Transfer state
  logic [7:0]  upper_ff, nxt_upper;     // Shift data upper
  logic [7:0]  lower_ff, nxt_lower;     // Shift data lower
  logic        so_ff, nxt_so;           // Data out pin level
  logic        sck_ff, nxt_sck;         // Clock out level
  logic        oe_ff, nxt_oe;           // Clock pin drive enable
  logic [9:0]  hc_ff, nxt_hc;           // Half-period counter
  logic [3:0]  cnt_ff, nxt_cnt;         // Bits done
  logic        ovr_ff, nxt_ovr;         // Overrun flag
  logic        armed_ff, nxt_armed;     // Overrun seen as one
  logic        rsv1_ff, nxt_rsv1;       // Reserved status bit
  logic        dseen_ff, nxt_dseen;     // A transfer has completed
  logic        irq_ff, nxt_irq;         // Completion pulse
  logic        ckprev_ff, nxt_ckprev;   // Synced clock, last cycle
  logic [31:0] prd_ff, nxt_prd;         // Read data
  logic        rdy_ff, nxt_rdy;         // APB ready
  logic        err_ff, nxt_err;         // APB error
  // ==========================================================
  // Decoded terms
  logic        sck_s, si_s;             // Synchronised pins
  logic        acc, wr, rd, busy, css, m16, tick, run_int;
  logic        rise, fall, ext_rise, last, abort, start;
  logic        h_scr, h_sss, h_sdu, h_sdl, h_rxf;
  logic [9:0]  half;
  logic [3:0]  len_m1;
  logic [1:0]  mode;
  logic        fifo_push, fifo_rdy, fifo_val, fifo_pop;
  logic [15:0] fifo_dout;

  // Pin inputs cross into pclk through two flops
  ssc_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    ({sck_i, si_i}),
    .d_out   ({sck_s, si_s})
  );

  // Completed words queue up; a full queue refuses new starts.
  // The word is taken from the next values so that the last bit is in it.
  ssc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_rdy),
    .in_data   ({nxt_upper, nxt_lower}),
    .out_valid (fifo_val),
    .out_ready (fifo_pop),
    .out_data  (fifo_dout)
  );

  // ==========================================================
  // Bus and clock decode
  always_comb begin
    acc      = psel & penable & ~rdy_ff;
    wr       = psel & penable & rdy_ff & pwrite;
    rd       = psel & penable & rdy_ff & ~pwrite;
    h_scr    = (paddr == {SMCC_IDX, 2'b00});
    h_sss    = (paddr == {SSS_IDX, 2'b00});
    h_sdu    = (paddr == {SDU_IDX, 2'b00});
    h_sdl    = (paddr == {SDL_IDX, 2'b00});
    h_rxf    = (paddr == {RXF_IDX, 2'b00});
    busy     = (state_ff == SSC_SHIFT);
    css      = scr_ff[CSS_BIT];
    mode     = scr_ff[7:6];
    m16      = (mode == SSC_M16);
    len_m1   = m16 ? LEN16_M1 : LEN8_M1;
    half     = HALF_TBL[scr_ff[2:0]];
    tick     = (hc_ff == half - 10'h001);
    run_int  = ~css & (busy | (mode == SSC_MCON));
    ext_rise = sck_s & ~ckprev_ff;
    rise     = css ? ext_rise : (run_int & tick & ~sck_ff);
    fall     = css ? (~sck_s & ckprev_ff) : (run_int & tick & sck_ff);
    last     = busy & rise & (cnt_ff == len_m1);
    abort    = wr & h_scr;
    // Mode codes 1x never start: continuous clock and the reserved code
    start    = wr & h_sss & pwdata[GO_BIT] & ~busy & ~mode[1] & fifo_rdy;
    fifo_push = last & ~abort;
    fifo_pop  = rd & h_rxf & fifo_val;
  end

  // ==========================================================
  // Next-state logic for the whole channel
  always_comb begin
    nxt_scr    = scr_ff;
    nxt_state  = state_ff;
    nxt_upper  = upper_ff;
    nxt_lower  = lower_ff;
    nxt_so     = so_ff;
    nxt_sck    = 1'b1;
    nxt_hc     = 10'h000;
    nxt_cnt    = cnt_ff;
    nxt_ovr    = ovr_ff;
    nxt_armed  = armed_ff;
    nxt_rsv1   = rsv1_ff;
    nxt_dseen  = dseen_ff;
    nxt_irq    = 1'b0;
    nxt_ckprev = sck_s;
    nxt_oe     = ~css;
    nxt_rdy    = acc;
    nxt_err    = acc & ~(h_scr | h_sss | h_sdu | h_sdl | h_rxf);
    nxt_prd    = prd_ff;
    // Prescaler; clock idles high when stopped
    if (run_int) begin
      nxt_hc  = tick ? 10'h000 : hc_ff + 10'h001;
      nxt_sck = tick ? ~sck_ff : sck_ff;
    end
    // Drive out on falling edge, sample in on rising edge
    if (busy & fall) begin
      nxt_so = lower_ff[0];
    end
    if (busy & rise) begin
      if (m16) begin
        nxt_upper = {si_s, upper_ff[7:1]};
        nxt_lower = {upper_ff[0], lower_ff[7:1]};
      end else begin
        nxt_lower = {si_s, lower_ff[7:1]};
      end
      nxt_cnt = cnt_ff + 4'h1;
    end
    // Last rising edge ends the transfer and stops the clock
    if (last) begin
      nxt_state = SSC_IDLE;
      nxt_irq   = 1'b1;
      nxt_dseen = 1'b1;
    end
    // Read data is captured in the first access cycle
    if (acc & ~pwrite) begin
      nxt_prd = 32'h0000_0000;
      if (h_scr) begin
        nxt_prd[7:0] = scr_ff;
      end else if (h_sss) begin
        nxt_prd[7:0] = {1'b1, so_ff, ovr_ff, 3'b000, rsv1_ff, busy};
      end else if (h_sdu) begin
        nxt_prd[7:0] = upper_ff;
      end else if (h_sdl) begin
        nxt_prd[7:0] = lower_ff;
      end else if (h_rxf) begin
        nxt_prd[15:0]    = fifo_dout;
        nxt_prd[RXV_BIT] = fifo_val;
        nxt_prd[RXF_BIT] = ~fifo_rdy;
      end
    end
    // Reading overrun as one arms its clear
    if (rd & h_sss & ovr_ff) begin
      nxt_armed = 1'b1;
    end
    // Control write resets the channel state mid-transfer
    if (abort) begin
      nxt_scr   = pwdata[7:0];
      nxt_state = SSC_IDLE;
      nxt_cnt   = 4'h0;
      nxt_hc    = 10'h000;
      nxt_sck   = 1'b1;
      nxt_irq   = 1'b0;
    end
    // Data and level writes are ignored mid-transfer to protect the chain
    if (wr & h_sss & ~busy) begin
      nxt_so   = pwdata[LVL_BIT];
      nxt_rsv1 = pwdata[RSV1_BIT];
    end
    if (wr & h_sss & ~pwdata[OVR_BIT] & armed_ff) begin
      nxt_ovr   = 1'b0;
      nxt_armed = 1'b0;
    end
    if (wr & h_sdu & ~busy) begin
      nxt_upper = pwdata[7:0];
    end
    if (wr & h_sdl & ~busy) begin
      nxt_lower = pwdata[7:0];
    end
    if (start) begin
      nxt_state = SSC_SHIFT;
      nxt_cnt   = 4'h0;
      nxt_hc    = 10'h000;
      nxt_sck   = 1'b1;
    end
    // Overrun set comes last so it beats a same-cycle clear
    if (css & ~busy & dseen_ff & ext_rise) begin
      nxt_ovr = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_ff    <= SMCC_RST;
      state_ff  <= SSC_IDLE;
      upper_ff  <= SDR_RST;
      lower_ff  <= SDR_RST;
      so_ff     <= SSS_RST[LVL_BIT];
      sck_ff    <= 1'b1;
      oe_ff     <= 1'b1;
      hc_ff     <= 10'h000;
      cnt_ff    <= 4'h0;
      ovr_ff    <= SSS_RST[OVR_BIT];
      armed_ff  <= 1'b0;
      rsv1_ff   <= SSS_RST[RSV1_BIT];
      dseen_ff  <= 1'b0;
      irq_ff    <= 1'b0;
      ckprev_ff <= 1'b0;
      prd_ff    <= 32'h0000_0000;
      rdy_ff    <= 1'b0;
      err_ff    <= 1'b0;
    end else begin
      scr_ff    <= nxt_scr;
      state_ff  <= nxt_state;
      upper_ff  <= nxt_upper;
      lower_ff  <= nxt_lower;
      so_ff     <= nxt_so;
      sck_ff    <= nxt_sck;
      oe_ff     <= nxt_oe;
      hc_ff     <= nxt_hc;
      cnt_ff    <= nxt_cnt;
      ovr_ff    <= nxt_ovr;
      armed_ff  <= nxt_armed;
      rsv1_ff   <= nxt_rsv1;
      dseen_ff  <= nxt_dseen;
      irq_ff    <= nxt_irq;
      ckprev_ff <= nxt_ckprev;
      prd_ff    <= nxt_prd;
      rdy_ff    <= nxt_rdy;
      err_ff    <= nxt_err;
    end
  end

  // Outputs: serial clock and its enable, data out, completion pulse, APB response
  assign sck_o    = sck_ff;
  assign sck_oe   = oe_ff;
  assign so_o     = so_ff;
  assign irq_done = irq_ff;
  assign prdata   = prd_ff;
  assign pready   = rdy_ff;
  assign pslverr  = err_ff;

  // ==========================================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int CONT_MAX = 520;
  logic [4:0] hlp_rises_ff;  // Rising clock edges in this transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hlp_rises_ff <= 5'h00;
    end else if (start) begin
      hlp_rises_ff <= 5'h00;
    end else if (busy & rise) begin
      hlp_rises_ff <= hlp_rises_ff + 5'h01;
    end
  end

  AST_ABORT: assert property (busy && abort |=> !busy)
    else $error("control write did not abort transfer");
  AST_START: assert property (start |=> busy && cnt_ff == 4'h0)
    else $error("start did not set busy");
  AST_WORDLEN: assert property (irq_ff |->
    hlp_rises_ff == ($past(m16) ? 5'h10 : 5'h08))
    else $error("wrong number of clock cycles in transfer");
  AST_IRQ: assert property (irq_ff |-> !busy ##1 !irq_ff)
    else $error("completion pulse wrong");
  AST_SRC: assert property (##1 oe_ff == !$past(css))
    else $error("clock pin direction does not follow source");
  AST_SODRIVE: assert property (busy && fall && !abort |=> so_ff == $past(lower_ff[0]))
    else $error("data out not driven on falling edge");
  AST_CHAIN16: assert property (busy && rise && m16 && !wr |=>
    upper_ff[7] == $past(si_s) && lower_ff[7] == $past(upper_ff[0]))
    else $error("16-bit chain broken");
  AST_OVR: assert property (css && !busy && dseen_ff && ext_rise |=> ovr_ff)
    else $error("overrun not flagged");
  AST_DIV: assert property (run_int && tick && !abort |=> sck_ff != $past(sck_ff))
    else $error("prescaled clock did not toggle");
  AST_CONT: assert property ((mode == SSC_MCON && !css)[*2] |-> ##[1:CONT_MAX]
    (sck_ff != $past(sck_ff)) || abort)
    else $error("continuous clock stalled");
  COV_8: cover property (irq_ff && !$past(m16));
  COV_16: cover property (irq_ff && $past(m16));
  COV_OVR: cover property ($rose(ovr_ff));
  COV_FULL: cover property (!fifo_rdy);
endmodule
`default_nettype wire

// File: verif/ssc_peer.sv
// Behavioural serial peer: shifts a word LSB first and can make an external clock
`default_nettype none
module ssc_peer (
  input  wire logic pclk,   // System clock, paces the external clock
  input  wire logic sck,    // Clock pin level as seen on the wire
  input  wire logic so,     // Data from the channel
  output logic      si,     // Data to the channel
  output logic      sck_x   // Clock made by this peer, idles high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tx;          // Word to send, loaded by the bench
  logic [15:0] rx;          // Word received, newest bit at the top
  // ==========================================================
  // Pin behaviour
  initial begin
    si    = 1'b0;
    sck_x = 1'b1;
    tx    = 16'h0000;
    rx    = 16'h0000;
  end
  // Next bit on every falling edge; the vacated bit is refilled inverted so the
  // line keeps moving after the word is spent
  always @(negedge sck) begin
    si <= tx[0];
    tx <= {~tx[0], tx[15:1]};
  end
  // Sample on the rising edge, LSB first into a right shift
  always @(posedge sck) begin
    rx <= {so, rx[15:1]};
  end
  // External clock pulses; slow enough for the two-flop input path, still between frames
  task automatic ext(input int n);
    repeat (n) begin
      repeat (6) @(posedge pclk);
      sck_x <= 1'b0;
      repeat (6) @(posedge pclk);
      sck_x <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// File: verif/test_sync_serial_8_16_channel.sv
// Self-checking bench of the serial channel with APB driver and read scoreboard
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_sync_serial_8_16_channel
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, dmy;
  logic              sck_o, sck_oe, so_o, irq_done, si, sck_x, lerr;
  wire logic         sck_pin = sck_oe ? sck_o : sck_x;   // Resolved clock pin
  int                n_fail = 0, n_checks = 0, cyc = 0, n_irq = 0, n_rise = 0;
  logic [63:0]       expq[$];                             // {mask, expected} per read
  integer            seed = 32'habb983e9;
  int                dv[8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
  ssc_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe(sck_oe), .si_i(si),
    .so_o(so_o), .irq_done(irq_done));
  ssc_peer peer (.pclk(pclk), .sck(sck_pin), .so(so_o), .si(si), .sck_x(sck_x));
  // ==========================================================
  // Clock, counters and the scoreboard side
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (irq_done === 1'b1) n_irq <= n_irq + 1;
  end
  always @(posedge sck_pin) n_rise++;
  // Oldest note is compared whenever a read answer appears
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      `CHK("read data", expq[0][31:0], prdata & expq[0][63:32])
      void'(expq.pop_front());
    end
  end
  // ==========================================================
  // Bus tasks; every change lands just after a rising edge
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rv);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin n_fail++; tally_and_finish(); end
    rv = prdata;
    lerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, dmy);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] e, input logic [31:0] m);
    expq.push_back({m, e});
    apb(1'b0, idx, 32'h0, dmy);
  endtask
  task automatic wait_irq();
    int k;
    for (k = 0; k < 20000; k++) begin
      @(posedge pclk);
      if (irq_done === 1'b1) break;
    end
    if (k == 20000) begin n_fail++; tally_and_finish(); end
  endtask
  task automatic wait_rise(output int t);
    logic p;
    int   k;
    p = sck_o;
    for (k = 0; k < 3000; k++) begin
      @(posedge pclk);
      if (sck_o === 1'b1 && p === 1'b0) break;
      p = sck_o;
    end
    if (k == 3000) begin n_fail++; tally_and_finish(); end
    t = cyc;
  endtask
  // One whole transfer; the peer's word and the device's word are checked both ways.
  // Mode field never 11 and bits 5:4 always zero in md
  task automatic xfer(input logic [7:0] md, input logic [15:0] d, input logic [15:0] pd,
                      input logic drain, output logic [15:0] w);
    logic [15:0] er, gr;   // Expected and seen word at the peer
    wr(SMCC_IDX, {24'h0, md});
    wr(SDU_IDX, {24'h0, d[15:8]});
    wr(SDL_IDX, {24'h0, d[7:0]});
    peer.tx = pd;
    n_rise = 0;
    w = md[6] ? pd : {d[15:8], pd[7:0]};
    wr(SSS_IDX, 32'h1);
    rdc(SSS_IDX, 32'h1, 32'h1);
    if (md[3]) peer.ext(md[6] ? 16 : 8);
    wait_irq();
    rdc(SSS_IDX, 32'h0, 32'h1);
    if (!md[3]) `CHK("clock edges", md[6] ? 16 : 8, n_rise)
    er = md[6] ? d : {d[7:0], 8'h0};
    gr = md[6] ? peer.rx : {peer.rx[15:8], 8'h0};
    `CHK("peer word", er, gr)
    rdc(SDL_IDX, {24'h0, w[7:0]}, 32'hFF);
    if (drain) rdc(RXF_IDX, {15'h0, 1'b1, w}, 32'h3FFFF);
  endtask
  // ==========================================================
  // Main sequence
  initial begin : main
    int          c, t0, t1, i, k;
    logic [15:0] ew[8];
    logic [15:0] w;
    {psel, penable, pwrite} = 3'b000;
    paddr = '0;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(SMCC_IDX, 32'h0, 32'hFFFFFFFF);
    rdc(SSS_IDX, 32'h80, 32'hFFFFFFFF);
    rdc(16'hFFB0, 32'h0, 32'hFFFFFFFF);
    `CHK("slave error", 1'b1, lerr)
    wr(SMCC_IDX, 32'h4D);
    rdc(SMCC_IDX, 32'h4D, 32'hFFFFFFFF);
    // Continuous clock at every ratio; a start must be refused meanwhile
    for (c = 0; c < 8; c++) begin
      wr(SMCC_IDX, 32'h80 | c);
      wait_rise(t0);
      wait_rise(t1);
      `CHK("clock period", dv[c], t1 - t0)
      `CHK("clock drive", 1'b1, sck_oe)
    end
    wr(SSS_IDX, 32'h1);
    rdc(SSS_IDX, 32'h0, 32'h1);
    // Slowest ratio, cut short by a control write: no completion may follow
    wr(SMCC_IDX, 32'h00);
    wr(SSS_IDX, 32'h1);
    repeat (200) @(posedge pclk);
    rdc(SSS_IDX, 32'h1, 32'h1);
    k = n_irq;
    wr(SMCC_IDX, 32'h00);
    rdc(SSS_IDX, 32'h0, 32'h1);
    repeat (9000) @(posedge pclk);
    `CHK("aborted completion", k, n_irq)
    xfer(8'h05, 16'h5AC3, 16'h3C96, 1'b1, w);
    xfer(8'h45, 16'hA55A, 16'h1EE1, 1'b1, w);
    // External clock: pin released, then a stray pulse after completion
    xfer(8'h08, 16'h00B4, 16'h00D2, 1'b1, w);
    `CHK("clock released", 1'b0, sck_oe)
    peer.ext(1);
    repeat (6) @(posedge pclk);
    rdc(SSS_IDX, 32'h20, 32'h20);
    wr(SSS_IDX, 32'h0);
    rdc(SSS_IDX, 32'h0, 32'h20);
    // Fill the received-word queue until a start is refused, then drain it
    for (i = 0; i < 8; i++) begin
      xfer(8'h05, 16'($random(seed)), 16'($random(seed)), 1'b0, ew[i]);
    end
    wr(SSS_IDX, 32'h1);
    rdc(SSS_IDX, 32'h0, 32'h1);
    for (i = 0; i < 8; i++) begin
      rdc(RXF_IDX, {14'h0, i == 0, 1'b1, ew[i]}, 32'h3FFFF);
    end
    rdc(RXF_IDX, 32'h0, 32'h30000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
